//--- asp_map.vh
// asp_map.vh: register map, field positions and timing constants of the serial port
// assumes inclusion by the serial port design files only
`ifndef ASP_MAP_VH
`define ASP_MAP_VH
// register byte addresses
`define ASP_ADDR_CTRL    4'h0
`define ASP_ADDR_BUF     4'h4
`define ASP_ADDR_BAUD    4'h8
`define ASP_ADDR_STAT    4'hc
// control register fields
`define ASP_CTL_MODE_LO  0
`define ASP_CTL_MODE_HI  1
`define ASP_CTL_REN      2
`define ASP_CTL_FILT     3
`define ASP_CTL_TB8      4
`define ASP_CTL_HALF     5
`define ASP_CTL_RB8      6
`define ASP_CTL_RXDONE   7
`define ASP_CTL_TXDONE   8
// modes
`define ASP_MODE1        2'h1
`define ASP_MODE2        2'h2
`define ASP_MODE3        2'h3
// reset values
`define ASP_CTRL_RST     9'h000
`define ASP_BAUD_RST     16'h0000
// divide-by-16 and majority sample points
`define ASP_DIV_LAST     4'hf
`define ASP_SMP_A        4'h7
`define ASP_SMP_B        4'h8
`define ASP_SMP_C        4'h9
`define ASP_RX_ONES      9'h1ff
`define ASP_TX_BITS      4'ha
// axi responses
`define ASP_RESP_OKAY    2'h0
`define ASP_RESP_SLVERR  2'h2
`endif

//--- asp_tick.v
// asp_tick.v: sixteen-times baud tick generator
// assumes a free-running system clock; timer overflow arrives as a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
`include "asp_map.vh"
module asp_tick (
   // clock and reset
   input  wire        ref_clk,
   input  wire        rst_n,
   // mode select
   input  wire [1:0]  mode,
   input  wire        half_rate,
   input  wire [15:0] reload,
   // tick out
   output reg         tick_q
);
   reg [15:0] cnt_q;
   reg        pre_q;
   wire       m3    = (mode == `ASP_MODE3);
   // mode 3 baud from a reloading timer overflow
   wire       ovf   = (cnt_q == 16'hffff);
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         cnt_q  <= 16'h0000;
         pre_q  <= 1'b0;
         tick_q <= 1'b0;
      end else begin
         if (ovf)
            cnt_q <= reload;
         else
            cnt_q <= cnt_q + 16'h0001;
         pre_q <= ~pre_q;
         if (m3)
            tick_q <= ovf;
         else if (half_rate)
            tick_q <= 1'b1;
         else
            tick_q <= pre_q;
      end
   end
   wire unused_ok = m3;
endmodule
`default_nettype wire

//--- asp_core.v
// asp_core.v: asynchronous serial port, modes 1 to 3, with an axi4-lite register slave
// assumes ref_clk at 50 MHz, rxd synchronous to ref_clk, remote side idling high
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "asp_map.vh"
module asp_core (
   // clock and reset
   input  wire        ref_clk,
   input  wire        rst_n,
   // axi4-lite write address
   input  wire [3:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   // axi4-lite write data
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   // axi4-lite write response
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // axi4-lite read address
   input  wire [3:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   // axi4-lite read data
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // serial line
   input  wire        rxd,
   output reg         txd_q
);
   // control and status
   reg  [8:0]  ctrl_q;
   reg  [15:0] baud_q;
   reg  [7:0]  rx_buf_q;
   wire [1:0]  mode     = ctrl_q[`ASP_CTL_MODE_HI:`ASP_CTL_MODE_LO];
   wire        nine     = (mode == `ASP_MODE2) || (mode == `ASP_MODE3);
   wire        on       = (mode != 2'h0);
   wire        tick;
   // axi write capture
   reg  [3:0]  aw_q;
   reg         aw_have_q;
   reg  [31:0] w_q;
   reg  [3:0]  ws_q;
   reg         w_have_q;
   wire        do_wr    = aw_have_q && w_have_q && !s_axi_bvalid;
   wire        wr_ok    = (aw_q == `ASP_ADDR_CTRL) || (aw_q == `ASP_ADDR_BUF) ||
                          (aw_q == `ASP_ADDR_BAUD);
   wire        buf_wr   = do_wr && (aw_q == `ASP_ADDR_BUF) && ws_q[0];
   wire        ctl_wr0  = do_wr && (aw_q == `ASP_ADDR_CTRL) && ws_q[0];
   wire        ctl_wr1  = do_wr && (aw_q == `ASP_ADDR_CTRL) && ws_q[1];
   // transmit state
   reg  [8:0]  tx_sh_q;
   reg  [3:0]  tx_div_q;
   reg         tx_req_q;
   reg         send_q;
   reg         data_q;
   reg         tx_first_q;
   reg         tx_set_q;
   // receive state
   reg  [3:0]  rx_div_q;
   reg  [8:0]  rx_sh_q;
   reg         rx_busy_q;
   reg         rx_prev_q;
   reg         rx_first_q;
   reg  [1:0]  smp_q;
   reg         rx_set_q;
   reg         rx_b8_q;
   reg         rx_ld_q;
   wire        maj      = (smp_q[1] & smp_q[0]) | (smp_q[1] & rxd) | (smp_q[0] & rxd);
   // first data bit sits at bit 7 of the shifter, under the start bit; buffer takes it back lsb first
   wire [7:0]  rx_rev;
   genvar      gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_rev
         assign rx_rev[gi] = rx_sh_q[7-gi];
      end
   endgenerate

   asp_tick u_tick (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .mode      (mode),
      .half_rate (ctrl_q[`ASP_CTL_HALF]),
      .reload    (baud_q),
      .tick_q    (tick)
   );

   // axi write channel
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         aw_q          <= 4'h0;
         aw_have_q     <= 1'b0;
         w_q           <= 32'h00000000;
         ws_q          <= 4'h0;
         w_have_q      <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `ASP_RESP_OKAY;
         baud_q        <= `ASP_BAUD_RST;
      end else begin
         s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_have_q && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_q      <= s_axi_awaddr;
            aw_have_q <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_q      <= s_axi_wdata;
            ws_q     <= s_axi_wstrb;
            w_have_q <= 1'b1;
         end
         if (do_wr) begin
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? `ASP_RESP_OKAY : `ASP_RESP_SLVERR;
            if (aw_q == `ASP_ADDR_BAUD && ws_q[0])
               baud_q[7:0] <= w_q[7:0];
            if (aw_q == `ASP_ADDR_BAUD && ws_q[1])
               baud_q[15:8] <= w_q[15:8];
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // axi read channel
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `ASP_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `ASP_RESP_OKAY;
            case (s_axi_araddr)
               `ASP_ADDR_CTRL: s_axi_rdata <= {23'h000000, ctrl_q};
               `ASP_ADDR_BUF:  s_axi_rdata <= {24'h000000, rx_buf_q};
               `ASP_ADDR_BAUD: s_axi_rdata <= {16'h0000, baud_q};
               `ASP_ADDR_STAT: s_axi_rdata <= {27'h0000000, rx_busy_q, data_q,
                                               send_q, tx_req_q, txd_q};
               default: begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= `ASP_RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // control register; hardware set wins over software clear
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         ctrl_q <= `ASP_CTRL_RST;
      end else begin
         if (ctl_wr0)
            ctrl_q[7:0] <= w_q[7:0];
         if (ctl_wr1)
            ctrl_q[8] <= w_q[8];
         if (tx_set_q)
            ctrl_q[`ASP_CTL_TXDONE] <= 1'b1;
         if (rx_ld_q) begin
            ctrl_q[`ASP_CTL_RB8]    <= rx_b8_q;
            ctrl_q[`ASP_CTL_RXDONE] <= 1'b1;
         end
      end
   end

   // transmitter
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         tx_sh_q    <= 9'h000;
         tx_div_q   <= 4'h0;
         tx_req_q   <= 1'b0;
         send_q     <= 1'b0;
         data_q     <= 1'b0;
         tx_first_q <= 1'b0;
         tx_set_q   <= 1'b0;
         txd_q      <= 1'b1;
      end else begin
         tx_set_q <= 1'b0;
         if (tick)
            tx_div_q <= tx_div_q + 4'h1;
         if (buf_wr && on) begin
            tx_sh_q  <= {(nine ? ctrl_q[`ASP_CTL_TB8] : 1'b1), w_q[7:0]};
            tx_req_q <= 1'b1;
            send_q   <= 1'b0;
            data_q   <= 1'b0;
         end else if (tick && tx_div_q == `ASP_DIV_LAST) begin
            if (tx_req_q) begin
               tx_req_q   <= 1'b0;
               send_q     <= 1'b1;
               tx_first_q <= 1'b1;
            end else if (send_q && !data_q) begin
               data_q <= 1'b1;
            end else if (data_q) begin
               if (!tx_first_q && tx_sh_q[8:1] == 8'h01) begin
                  tx_sh_q  <= 9'h000;
                  send_q   <= 1'b0;
                  data_q   <= 1'b0;
                  tx_set_q <= 1'b1;
               end else begin
                  tx_sh_q    <= {tx_first_q, tx_sh_q[8:1]};
                  tx_first_q <= 1'b0;
               end
            end
         end
         if (data_q)
            txd_q <= tx_sh_q[0];
         else
            txd_q <= !send_q;
      end
   end

   // receiver
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         rx_div_q   <= 4'h0;
         rx_sh_q    <= `ASP_RX_ONES;
         rx_busy_q  <= 1'b0;
         rx_prev_q  <= 1'b1;
         rx_first_q <= 1'b0;
         smp_q      <= 2'h3;
         rx_set_q   <= 1'b0;
         rx_b8_q    <= 1'b0;
         rx_ld_q    <= 1'b0;
         rx_buf_q   <= 8'h00;
      end else begin
         rx_ld_q <= 1'b0;
         rx_set_q <= 1'b0;
         if (tick) begin
            rx_prev_q <= rxd;
            rx_div_q  <= rx_div_q + 4'h1;
            if (!rx_busy_q && on && ctrl_q[`ASP_CTL_REN] && rx_prev_q && !rxd) begin
               rx_div_q   <= 4'h1;
               rx_sh_q    <= `ASP_RX_ONES;
               rx_busy_q  <= 1'b1;
               rx_first_q <= 1'b1;
            end else if (rx_busy_q) begin
               if (rx_div_q == `ASP_SMP_A)
                  smp_q[1] <= rxd;
               if (rx_div_q == `ASP_SMP_B)
                  smp_q[0] <= rxd;
               if (rx_div_q == `ASP_SMP_C) begin
                  rx_first_q <= 1'b0;
                  if (rx_first_q && maj) begin
                     rx_busy_q <= 1'b0;
                  end else if (!rx_sh_q[8]) begin
                     rx_busy_q <= 1'b0;
                     if (!ctrl_q[`ASP_CTL_RXDONE] &&
                         (!ctrl_q[`ASP_CTL_FILT] || maj)) begin
                        rx_buf_q <= rx_rev;
                        rx_b8_q  <= maj;
                        rx_ld_q  <= 1'b1;
                     end
                  end else begin
                     rx_sh_q <= {rx_sh_q[7:0], maj};
                  end
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

//--- asp_remote.sv
// asp_remote.sv: far-side line partner that sends and captures frames
// assumes its tasks are called just after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module asp_remote (
   // clock
   input  wire logic ref_clk,
   // line
   output logic      rxd,
   input  wire logic txd
);
   int bit_clks = 16;
   initial rxd = 1'b1;
   task automatic send(input logic [10:0] f, input int n, input bit gl);
      for (int i = 0; i < n; i++) begin
         rxd <= f[i];
         repeat (8) @(posedge ref_clk);
         if (gl) rxd <= ~f[i];
         @(posedge ref_clk);
         rxd <= f[i];
         repeat (bit_clks - 9) @(posedge ref_clk);
      end
      rxd <= 1'b1;
   endtask
   // mid-bit capture of a frame on the transmit line
   task automatic recv(input int n, output logic [10:0] f);
      f = 11'h0;
      while (txd !== 1'b0) @(posedge ref_clk);
      repeat (bit_clks / 2) @(posedge ref_clk);
      for (int i = 0; i < n; i++) begin
         f[i] = txd;
         repeat (bit_clks) @(posedge ref_clk);
      end
   endtask
   // short low pulse, too short to pass as a start bit
   task automatic pulse(input int n);
      rxd <= 1'b0;
      repeat (n) @(posedge ref_clk);
      rxd <= 1'b1;
   endtask
endmodule
`default_nettype wire

//--- asp_core_sva.sv
// asp_core_sva.sv: checker for the register slave handshakes and the line
// assumes it is bound to asp_core and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module asp_chk (
   // clock and reset
   input wire logic        ref_clk,
   input wire logic        rst_n,
   // register bus
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // line
   input wire logic        txd_q
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
   a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
   a_ready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
      else $error("awready longer than one cycle");
   a_ar_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_ar_cause: assert property ($rose(s_axi_arready) |-> $past(s_axi_arvalid))
      else $error("arready without request");
   a_w_cause: assert property ($rose(s_axi_wready) |-> $past(s_axi_wvalid))
      else $error("wready without data");
   a_b_bounded: assert property (s_axi_wvalid && s_axi_wready |-> ##[1:4] s_axi_bvalid)
      else $error("write response missing");
   a_reset_idle: assert property (disable iff (1'b0) !rst_n |=>
      !s_axi_bvalid && !s_axi_rvalid && txd_q) else $error("outputs not idle in reset");
   a_start_low: assert property ($fell(txd_q) |=> !txd_q [*8])
      else $error("start bit too short");
   cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h2);
   cover property ($fell(txd_q));
   cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind asp_core asp_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .txd_q(txd_q));
`default_nettype wire

//--- test_async_serial_port_modes_1_to_3.sv
// test_async_serial_port_modes_1_to_3.sv: self-checking bench for asp_core
// assumes asp_remote on the line and asp_chk bound to the core
`timescale 1ns/1ps
`default_nettype none
module test_async_serial_port_modes_1_to_3;
   logic        ref_clk = 1'b0, rst_n = 1'b0;
   logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata;
   logic        awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
   logic        awrdy, wrdy, bvalid, arrdy, rvalid, rxd, txd;
   logic [1:0]  bresp, rresp;
   int          error_cnt = 0, checked = 0, cyc = 0;
   always #10 ref_clk = ~ref_clk;
   asp_core dut (.ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
      .s_axi_awready(awrdy), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
      .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arrdy), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rxd(rxd), .txd_q(txd));
   asp_remote rem (.ref_clk(ref_clk), .rxd(rxd), .txd(txd));
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic conclude();
      if (error_cnt == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 40000) begin
         error_cnt++;
         conclude();
      end
   end
   // register bus write, address and data offered together
   task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      awaddr <= a;
      wdata <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (awrdy === 1'b1) awv <= 1'b0;
         if (wrdy === 1'b1) wv <= 1'b0;
      end while (awv || wv);
      while (bvalid !== 1'b1) @(posedge ref_clk);
      bready <= 1'b1;
      r = bresp;
      @(posedge ref_clk);
      bready <= 1'b0;
   endtask
   // register bus read and compare
   task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] e);
      araddr <= a;
      arv <= 1'b1;
      do @(posedge ref_clk); while (arrdy !== 1'b1);
      arv <= 1'b0;
      while (rvalid !== 1'b1) @(posedge ref_clk);
      rready <= 1'b1;
      chk(nm, e, rdata);
      @(posedge ref_clk);
      rready <= 1'b0;
   endtask
   // reset values, timer reload access, unmapped write
   task automatic t_regs();
      logic [1:0] r;
      rchk("ctrl reset", 4'h0, 32'h0);
      rchk("reload reset", 4'h8, 32'h0);
      rchk("status reset", 4'hc, 32'h1);
      wr(4'h8, 32'hfff0, r);
      rchk("reload", 4'h8, 32'hfff0);
      wr(4'hc, 32'h1f, r);
      chk("unmapped write", 32'h2, {30'h0, r});
      rchk("status kept", 4'hc, 32'h1);
   endtask
   // one transmitted frame on the line, then the done flag
   task automatic t_tx(input logic [8:0] c, input int n, input logic [7:0] d, input int bt);
      logic [1:0]  r;
      logic [10:0] f;
      rem.bit_clks = bt;
      wr(4'h0, {23'h0, c}, r);
      fork
         rem.recv(n, f);
         wr(4'h4, {24'h0, d}, r);
      join
      chk("tx frame", n == 10 ? {1'b1, d, 1'b0} : {1'b1, c[4], d, 1'b0}, f);
      repeat (2 * bt) @(posedge ref_clk);
      rchk("tx done", 4'h0, {23'h0, c | 9'h100});
      rchk("line idle", 4'hc, 32'h1);
   endtask
   // short low pulse must not start a frame
   task automatic t_false();
      logic [1:0] r;
      rem.bit_clks = 16;
      wr(4'h0, 32'h26, r);
      rem.pulse(4);
      repeat (20) @(posedge ref_clk);
      rchk("rx idle", 4'hc, 32'h1);
      rchk("no load", 4'h0, 32'h26);
   endtask
   // one received frame, then buffer and control readback
   task automatic t_rx(input logic [10:0] f, input int n, input bit gl, input logic [31:0] eb,
                       input logic [31:0] ec);
      rem.send(f, n, gl);
      repeat (4) @(posedge ref_clk);
      rchk("rx buffer", 4'h4, eb);
      rchk("rx control", 4'h0, ec);
   endtask
   initial begin
      logic [1:0] r;
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      t_regs();
      t_tx(9'h021, 10, 8'ha5, 16);
      t_tx(9'h032, 11, 8'h5a, 16);
      t_tx(9'h022, 11, 8'h80, 16);
      t_tx(9'h002, 11, 8'h3c, 32);
      t_false();
      t_rx({2'b11, 8'hc3, 1'b0}, 11, 1, 32'hc3, 32'he6);
      wr(4'h0, 32'h26, r);
      t_rx({2'b10, 8'h01, 1'b0}, 11, 0, 32'h01, 32'ha6);
      t_rx({2'b11, 8'h77, 1'b0}, 11, 0, 32'h01, 32'ha6);
      wr(4'h0, 32'h2d, r);
      t_rx({2'b00, 8'h55, 1'b0}, 10, 0, 32'h01, 32'h2d);
      t_rx({2'b01, 8'h55, 1'b0}, 10, 0, 32'h55, 32'hed);
      conclude();
   end
endmodule
`default_nettype wire
